// ### verilog/obl_regs.svh
// Offsets, field positions and reset values of the option byte loader
`ifndef OBL_REGS_SVH
`define OBL_REGS_SVH

// ****************************************************************
// Flash locations of the option bytes
// ****************************************************************
`define OBL_USER_BYTE_ADDR    16'h0000
`define OBL_SPARE_BYTE_ADDR   16'h0001
`define OBL_ERASED_BYTE       8'hff

// ****************************************************************
// Option byte field positions
// ****************************************************************
`define OBL_BIT_WDT_RESETS    7
`define OBL_BIT_WDT_BY_INSTR  6
`define OBL_BIT_OSC_HI        5
`define OBL_BIT_OSC_LO        4
`define OBL_BIT_BO_ALWAYS     3
`define OBL_BIT_CODE_READ     2
`define OBL_BIT_RESERVED      1
`define OBL_BIT_FLASH_WRITE   0

// ****************************************************************
// Loader control port map
// ****************************************************************
`define OBL_CTRL_ADDR         4'h0
`define OBL_STATUS_ADDR       4'h1
`define OBL_CTRL_SW_RESET     0
`define OBL_STAT_VALID        0
`define OBL_STAT_RSVD_BAD     1
`define OBL_STAT_WDT_RUN      2
`define OBL_STAT_LOADS_LO     4
`define OBL_READ_NONE         8'h00

`endif

// ### verilog/obl_pkg.sv
// Types shared by the option byte loader modules
package obl_pkg;

   // Bit order matches the user option byte in flash
   typedef struct packed {
      logic       watchdog_timeout_resets;
      logic       watchdog_start_by_instruction;
      logic [1:0] oscillator_drive_select;
      logic       brownout_always_active;
      logic       code_readable;
      logic       reserved_one;
      logic       flash_writes_allowed;
   } obl_opt_t;

   typedef struct packed {
      logic       user_prog;
      logic       page_erase;
      logic       mass_erase;
   } obl_flash_op_t;

   typedef enum logic [2:0] {
      OBL_F_IDLE,
      OBL_F_REQ_USER,
      OBL_F_WAIT_USER,
      OBL_F_REQ_SPARE,
      OBL_F_WAIT_SPARE
   } obl_fetch_state_t;

endpackage

// ### verilog/obl_fetch.sv
// Flash reader that fetches both option bytes after each reset
`include "obl_regs.svh"
module obl_fetch
   import obl_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        start,
   output logic             done,
   output logic [7:0]       user_byte,
   output logic [7:0]       spare_byte,
   output logic             flash_rd_req,
   output logic [15:0]      flash_addr,
   input  wire logic [7:0]  flash_rdata,
   input  wire logic        flash_rd_valid
);

   obl_fetch_state_t state_q, state_d;
   logic [7:0]       user_q, user_d;
   logic [7:0]       spare_q, spare_d;
   logic             done_q, done_d;

   always_comb
   begin
      state_d = state_q;
      user_d  = user_q;
      spare_d = spare_q;
      done_d  = 1'b0;
      unique case (state_q)
         OBL_F_IDLE:       ;
         OBL_F_REQ_USER:   state_d = OBL_F_WAIT_USER;
         OBL_F_WAIT_USER:
            if (flash_rd_valid)
            begin
               user_d  = flash_rdata;
               state_d = OBL_F_REQ_SPARE;
            end
         OBL_F_REQ_SPARE:  state_d = OBL_F_WAIT_SPARE;
         OBL_F_WAIT_SPARE:
            if (flash_rd_valid)
            begin
               spare_d = flash_rdata;
               done_d  = 1'b1;
               state_d = OBL_F_IDLE;
            end
      endcase
      // A new reset abandons a fetch in flight and starts over
      if (start)
      begin
         state_d = OBL_F_REQ_USER;
         done_d  = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= OBL_F_IDLE;
         user_q  <= `OBL_ERASED_BYTE;
         spare_q <= `OBL_ERASED_BYTE;
         done_q  <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         user_q  <= user_d;
         spare_q <= spare_d;
         done_q  <= done_d;
      end
   end

   assign done         = done_q;
   assign user_byte    = user_q;
   assign spare_byte   = spare_q;
   assign flash_rd_req = (state_q == OBL_F_REQ_USER) || (state_q == OBL_F_REQ_SPARE);
   assign flash_addr   = (state_q == OBL_F_REQ_SPARE || state_q == OBL_F_WAIT_SPARE) ?
                         `OBL_SPARE_BYTE_ADDR : `OBL_USER_BYTE_ADDR;

endmodule // obl_fetch

// ### verilog/option_byte_loader.sv
// Option byte loader: reset-time capture of the user option byte and its decoded controls
//
// Contract
// - Every reset kind fetches and latches option byte
// - Processor held in reset until load finishes
// - Option latches invisible to software
// - Flash changes act only after next reset
// - Byte 0000H configures; 0001H reserved, unused
// - Bit 7: interrupt or short reset on time-out
// - Bit 6: watchdog free-running or instruction-started
// - Bits 5:4 select oscillator drive mode
// - Bit 3: brownout kept on in stop
// - Bit 2: code readable, full debugger access
// - Bit 0: user flash writes allowed
`include "obl_regs.svh"
module option_byte_loader
   import obl_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          rst,
   // Reset sources
   input  wire logic          system_reset_req,
   input  wire logic          pin_reset,
   input  wire logic          stop_mode_recovery,
   output logic               cpu_reset_hold,
   // Flash read port
   output logic               flash_rd_req,
   output logic [15:0]        flash_addr,
   input  wire logic [7:0]    flash_rdata,
   input  wire logic          flash_rd_valid,
   // Watchdog
   input  wire logic          watchdog_timeout,
   input  wire logic          watchdog_instr,
   input  wire logic          watchdog_stop_powerdown,
   input  wire logic          stop_mode,
   output logic               watchdog_irq_req,
   output logic               watchdog_short_reset,
   output logic               watchdog_run,
   // Oscillator and brownout
   output logic [1:0]         oscillator_drive_select,
   output logic               brownout_enable,
   // Read protection
   output logic               code_readable,
   output logic               debugger_full_access,
   // Flash write protection
   input  obl_flash_op_t      user_flash_req,
   input  wire logic          debugger_mass_erase_req,
   output obl_flash_op_t      user_flash_grant,
   output logic               debugger_mass_erase_grant,
   // Loader control port
   input  wire logic [3:0]    reg_addr,
   input  wire logic [7:0]    reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic [7:0]         reg_rdata
);

   // ****************************************************************
   // Reset sequencing
   // ****************************************************************
   logic       sw_reset_req;
   logic       reset_event;
   logic       power_start_q, power_start_d;
   logic       loading_q, loading_d;
   logic       fetch_start;
   logic       fetch_done;
   logic [7:0] fetched_user;
   logic [7:0] fetched_spare;

   // Watchdog short reset loops back as a reset of its own
   assign reset_event = system_reset_req | pin_reset | stop_mode_recovery
                      | watchdog_short_reset | sw_reset_req;
   assign fetch_start = power_start_q | reset_event;

   always_comb
   begin
      power_start_d = 1'b0;
      loading_d     = loading_q;
      if (fetch_done)
         loading_d = 1'b0;
      // A reset in the finishing cycle restarts the load
      if (fetch_start)
         loading_d = 1'b1;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         power_start_q <= 1'b1;
         loading_q     <= 1'b1;
      end
      else
      begin
         power_start_q <= power_start_d;
         loading_q     <= loading_d;
      end
   end

   assign cpu_reset_hold = loading_q;

   obl_fetch u_fetch (
      .sys_clk        (sys_clk),
      .rst            (rst),
      .start          (fetch_start),
      .done           (fetch_done),
      .user_byte      (fetched_user),
      .spare_byte     (fetched_spare),
      .flash_rd_req   (flash_rd_req),
      .flash_addr     (flash_addr),
      .flash_rdata    (flash_rdata),
      .flash_rd_valid (flash_rd_valid)
   );

   // ****************************************************************
   // Option configuration latches
   // ****************************************************************
   obl_opt_t   opt_q, opt_d;
   logic       rsvd_bad_q, rsvd_bad_d;
   logic [3:0] loads_q, loads_d;
   logic       rsvd_clear;

   always_comb
   begin
      opt_d      = opt_q;
      rsvd_bad_d = rsvd_bad_q;
      loads_d    = loads_q;
      // Only a finished fetch updates them; flash edits wait for reset
      if (fetch_done && !fetch_start)
      begin
         opt_d = obl_opt_t'(fetched_user);
         if (loads_q != 4'hf)
            loads_d = loads_q + 4'h1;
      end
      if (rsvd_clear)
         rsvd_bad_d = 1'b0;
      // Spare byte is only checked, never used as configuration
      if (fetch_done && !fetch_start &&
          (!fetched_user[`OBL_BIT_RESERVED] || fetched_spare != `OBL_ERASED_BYTE))
         rsvd_bad_d = 1'b1;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         opt_q      <= obl_opt_t'(`OBL_ERASED_BYTE);
         rsvd_bad_q <= 1'b0;
         loads_q    <= 4'h0;
      end
      else
      begin
         opt_q      <= opt_d;
         rsvd_bad_q <= rsvd_bad_d;
         loads_q    <= loads_d;
      end
   end

   // ****************************************************************
   // Watchdog controls
   // ****************************************************************
   logic instr_run_q, instr_run_d;

   always_comb
   begin
      instr_run_d = instr_run_q;
      if (watchdog_instr)
         instr_run_d = 1'b1;
      // Only a reset or stop recovery can stop it again
      if (reset_event || loading_q)
         instr_run_d = 1'b0;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         instr_run_q <= 1'b0;
      else
         instr_run_q <= instr_run_d;
   end

   always_comb
   begin
      if (opt_q.watchdog_start_by_instruction)
         watchdog_run = instr_run_q;
      else
         watchdog_run = !loading_q && !(stop_mode && watchdog_stop_powerdown);
   end

   // Time-out answered only once the configuration is valid
   assign watchdog_short_reset = watchdog_timeout && !loading_q &&
                                 opt_q.watchdog_timeout_resets;
   assign watchdog_irq_req     = watchdog_timeout && !loading_q &&
                                 !opt_q.watchdog_timeout_resets;

   // ****************************************************************
   // Oscillator, brownout and protection
   // ****************************************************************
   assign oscillator_drive_select = opt_q.oscillator_drive_select;
   assign brownout_enable         = opt_q.brownout_always_active || !stop_mode;
   assign code_readable           = opt_q.code_readable;
   assign debugger_full_access    = opt_q.code_readable;

   always_comb
   begin
      user_flash_grant = '0;
      if (opt_q.flash_writes_allowed && !loading_q)
      begin
         user_flash_grant.user_prog  = user_flash_req.user_prog;
         user_flash_grant.page_erase = user_flash_req.page_erase;
         user_flash_grant.mass_erase = user_flash_req.mass_erase;
      end
   end

   // Debugger mass erase survives write protection
   assign debugger_mass_erase_grant = debugger_mass_erase_req && !loading_q;

   // ****************************************************************
   // Loader control port
   // ****************************************************************
   logic [7:0] rdata_q, rdata_d;
   logic [7:0] status_word;

   assign sw_reset_req = reg_wr && reg_addr == `OBL_CTRL_ADDR && reg_wdata[`OBL_CTRL_SW_RESET];
   assign rsvd_clear   = reg_wr && reg_addr == `OBL_STATUS_ADDR && reg_wdata[`OBL_STAT_RSVD_BAD];

   always_comb
   begin
      status_word                        = `OBL_READ_NONE;
      status_word[`OBL_STAT_VALID]       = !loading_q;
      status_word[`OBL_STAT_RSVD_BAD]    = rsvd_bad_q;
      status_word[`OBL_STAT_WDT_RUN]     = watchdog_run;
      status_word[`OBL_STAT_LOADS_LO+:4] = loads_q;
   end

   // Option latches have no address here at all
   always_comb
   begin
      rdata_d = `OBL_READ_NONE;
      if (reg_rd && reg_addr == `OBL_STATUS_ADDR)
         rdata_d = status_word;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         rdata_q <= `OBL_READ_NONE;
      else
         rdata_q <= rdata_d;
   end

   assign reg_rdata = rdata_q;

endmodule // option_byte_loader

// ### test/obl_monitor.sv
// Port-level checks for the option byte loader
module obl_monitor
   import obl_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        system_reset_req,
   input wire logic        pin_reset,
   input wire logic        stop_mode_recovery,
   input wire logic        cpu_reset_hold,
   input wire logic        flash_rd_req,
   input wire logic [15:0] flash_addr,
   input wire logic        watchdog_timeout,
   input wire logic        watchdog_irq_req,
   input wire logic        watchdog_short_reset,
   input wire logic        stop_mode,
   input wire logic [1:0]  oscillator_drive_select,
   input wire logic        brownout_enable,
   input wire logic        code_readable,
   input wire logic        debugger_full_access,
   input obl_flash_op_t    user_flash_req,
   input obl_flash_op_t    user_flash_grant,
   input wire logic        debugger_mass_erase_grant,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata
);
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_restart_load: assert property ((system_reset_req || pin_reset || stop_mode_recovery) |=> cpu_reset_hold)
      else $error("reset source did not restart load");
   a_hold_no_grant: assert property (cpu_reset_hold |-> user_flash_grant == 3'h0 && !debugger_mass_erase_grant)
      else $error("grant while loading");
   a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data without read");
   a_cfg_frozen: assert property (!cpu_reset_hold && !$past(cpu_reset_hold) |->
      $stable(oscillator_drive_select) && $stable(code_readable))
      else $error("configuration moved outside load");
   a_fetch_addr: assert property (flash_rd_req |-> flash_addr inside {16'h0000, 16'h0001})
      else $error("fetch outside option bytes");
   a_wdt_response: assert property (watchdog_timeout && !cpu_reset_hold |-> watchdog_irq_req ^ watchdog_short_reset)
      else $error("time-out response not exclusive");
   a_brownout_run: assert property (!stop_mode |-> brownout_enable)
      else $error("brownout off outside stop");
   a_debug_access: assert property (debugger_full_access == code_readable)
      else $error("debugger access differs from read enable");
   a_grant_subset: assert property ((user_flash_grant & ~user_flash_req) == 3'h0)
      else $error("grant without request");
endmodule // obl_monitor

// ### test/obl_flash_model.sv
// Behavioural flash holding the two option bytes
module obl_flash_model (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        flash_rd_req,
   input  wire logic [15:0] flash_addr,
   input  wire logic [7:0]  user_byte,
   input  wire logic [7:0]  spare_byte,
   input  wire logic        slow,
   output logic [7:0]       flash_rdata,
   output logic             flash_rd_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0]  wait_q;
   logic        busy_q;
   logic [15:0] addr_q;
   logic [7:0]  last_q;
   // Idle data is the inverse of the last byte so a stale sample shows
   assign flash_rdata = flash_rd_valid ? (addr_q == 16'h0000 ? user_byte : spare_byte) : ~last_q;
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         busy_q <= 1'b0;
         flash_rd_valid <= 1'b0;
         last_q <= 8'h00;
      end
      else
      begin
         flash_rd_valid <= busy_q && wait_q == 3'h0;
         if (flash_rd_valid)
            last_q <= flash_rdata;
         if (flash_rd_req)
         begin
            busy_q <= 1'b1;
            addr_q <= flash_addr;
            wait_q <= slow ? 3'h4 : 3'h0;
         end
         else if (wait_q != 3'h0)
            wait_q <= wait_q - 3'h1;
         else
            busy_q <= 1'b0;
      end
   end
endmodule // obl_flash_model

// ### test/test_option_byte_loader.sv
// Directed bench for the option byte loader
module test_option_byte_loader import obl_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic          sys_clk = 1'b0, rst = 1'b1, slow = 1'b0;
   logic          system_reset_req = 1'b0, pin_reset = 1'b0, stop_mode_recovery = 1'b0;
   logic          watchdog_timeout = 1'b0, watchdog_instr = 1'b0, stop_mode = 1'b0;
   logic          debugger_mass_erase_req = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic          cpu_reset_hold, flash_rd_req, flash_rd_valid, watchdog_irq_req, watchdog_short_reset;
   logic          watchdog_run, brownout_enable, code_readable, debugger_full_access, debugger_mass_erase_grant;
   logic [1:0]    oscillator_drive_select;
   logic [3:0]    reg_addr = 4'h0;
   logic [7:0]    reg_wdata = 8'h00, reg_rdata, flash_rdata, rd;
   logic [7:0]    user_byte = 8'hff, spare_byte = 8'hff;
   logic [15:0]   flash_addr;
   obl_flash_op_t user_flash_req = 3'h0, user_flash_grant;
   int            fails = 0, n_compared = 0, cyc = 0;
   logic [7:0]    cfg_tab [8] = '{8'h02, 8'h9b, 8'h66, 8'hfa, 8'h3f, 8'hc3, 8'h2e, 8'hd7};

   option_byte_loader u_option_byte_loader (.sys_clk(sys_clk), .rst(rst),
      .system_reset_req(system_reset_req), .pin_reset(pin_reset), .stop_mode_recovery(stop_mode_recovery),
      .cpu_reset_hold(cpu_reset_hold), .flash_rd_req(flash_rd_req), .flash_addr(flash_addr),
      .flash_rdata(flash_rdata), .flash_rd_valid(flash_rd_valid), .watchdog_timeout(watchdog_timeout),
      .watchdog_instr(watchdog_instr), .watchdog_stop_powerdown(1'b0), .stop_mode(stop_mode),
      .watchdog_irq_req(watchdog_irq_req), .watchdog_short_reset(watchdog_short_reset),
      .watchdog_run(watchdog_run), .oscillator_drive_select(oscillator_drive_select),
      .brownout_enable(brownout_enable), .code_readable(code_readable),
      .debugger_full_access(debugger_full_access), .user_flash_req(user_flash_req),
      .debugger_mass_erase_req(debugger_mass_erase_req), .user_flash_grant(user_flash_grant),
      .debugger_mass_erase_grant(debugger_mass_erase_grant), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   obl_flash_model u_obl_flash_model (.sys_clk(sys_clk), .rst(rst), .flash_rd_req(flash_rd_req),
      .flash_addr(flash_addr), .user_byte(user_byte), .spare_byte(spare_byte), .slow(slow),
      .flash_rdata(flash_rdata), .flash_rd_valid(flash_rd_valid));

   always #4 sys_clk = ~sys_clk;

   // ****************************************
   // Tasks
   // ****************************************
   task automatic wrap_up();
      $display("compared=%0d fails=%0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Load time depends on flash latency, so wait on the hold flag
   task automatic wait_load();
      int n;
      n = 0;
      @(posedge sys_clk);
      #1 chk({7'h0, cpu_reset_hold}, 8'h01);
      while (cpu_reset_hold === 1'b1 && n < 60)
      begin
         @(posedge sys_clk);
         #1 n++;
      end
      chk({7'h0, cpu_reset_hold}, 8'h00);
   endtask
   task automatic kick(input int kind);
      @(posedge sys_clk);
      case (kind)
         0: system_reset_req <= 1'b1;
         1: pin_reset <= 1'b1;
         2: stop_mode_recovery <= 1'b1;
         default:
         begin
            reg_addr <= 4'h0;
            reg_wdata <= 8'h01;
            reg_wr <= 1'b1;
         end
      endcase
      @(posedge sys_clk);
      {system_reset_req, pin_reset, stop_mode_recovery, reg_wr} <= 4'h0;
      wait_load();
   endtask
   task automatic check_cfg(input logic [7:0] ub);
      @(posedge sys_clk);
      stop_mode <= 1'b1;
      user_flash_req <= 3'h7;
      debugger_mass_erase_req <= 1'b1;
      @(posedge sys_clk);
      #1 chk({6'h0, oscillator_drive_select}, {6'h0, ub[5:4]});
      chk({7'h0, brownout_enable}, {7'h0, ub[3]});
      chk({6'h0, code_readable, debugger_full_access}, {6'h0, ub[2], ub[2]});
      chk({4'h0, user_flash_grant, debugger_mass_erase_grant}, {4'h0, {3{ub[0]}}, 1'b1});
      chk({7'h0, watchdog_run}, {7'h0, ~ub[6]});
      @(posedge sys_clk);
      stop_mode <= 1'b0;
      watchdog_timeout <= 1'b1;
      // Short reset reloads at the next edge, so look before it
      #1 chk({6'h0, watchdog_irq_req, watchdog_short_reset}, {6'h0, ~ub[7], ub[7]});
      @(posedge sys_clk);
      watchdog_timeout <= 1'b0;
      if (ub[7])
         wait_load();
      @(posedge sys_clk);
      watchdog_instr <= 1'b1;
      @(posedge sys_clk);
      watchdog_instr <= 1'b0;
      #1 chk({7'h0, watchdog_run}, 8'h01);
   endtask

   // ****************************************
   // Sequence
   // ****************************************
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fails++;
         wrap_up();
      end
   end
   initial
   begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      wait_load();
      check_cfg(8'hff);
      for (int i = 0; i < 8; i++)
      begin
         user_byte <= cfg_tab[i];
         slow <= i[0];
         kick(i % 4);
         check_cfg(cfg_tab[i]);
      end
      user_byte <= 8'h00;
      repeat (8) @(posedge sys_clk);
      #1 chk({5'h0, oscillator_drive_select, code_readable}, 8'h03);
      reg_read(4'h1, rd);
      chk(rd & 8'h03, 8'h01);
      spare_byte <= 8'h7f;
      kick(0);
      reg_read(4'h1, rd);
      chk(rd & 8'h03, 8'h03);
      reg_write(4'h1, 8'h02);
      reg_read(4'h1, rd);
      chk(rd & 8'h03, 8'h01);
      reg_write(4'h7, 8'hff);
      reg_read(4'h7, rd);
      chk(rd, 8'h00);
      wrap_up();
   end
endmodule // test_option_byte_loader

bind option_byte_loader obl_monitor u_obl_monitor (.sys_clk(sys_clk), .rst(rst),
   .system_reset_req(system_reset_req), .pin_reset(pin_reset), .stop_mode_recovery(stop_mode_recovery),
   .cpu_reset_hold(cpu_reset_hold), .flash_rd_req(flash_rd_req), .flash_addr(flash_addr),
   .watchdog_timeout(watchdog_timeout), .watchdog_irq_req(watchdog_irq_req),
   .watchdog_short_reset(watchdog_short_reset), .stop_mode(stop_mode),
   .oscillator_drive_select(oscillator_drive_select), .brownout_enable(brownout_enable),
   .code_readable(code_readable), .debugger_full_access(debugger_full_access),
   .user_flash_req(user_flash_req), .user_flash_grant(user_flash_grant),
   .debugger_mass_erase_grant(debugger_mass_erase_grant), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
